// ### verilog/pgd_regs_pkg.sv
// Constants, field layouts and carriers for the PLL status and driver register bank
// Behaviour
// - Status bit 4 shows selected reference input
// - Status bit 3 shows feedback clock presence
// - Status bit 2 shows reference B presence
// - Status bit 1 shows reference A presence
// - Status bit 0 shows digital lock flag
// - Driver 0 bit 4 powers down pair 0/1
// - Driver 2 bit 4 powers down pair 2/3
// - Bits 2:1 select swing, default 780 mV
// - Bit 0 powers down that single driver
// - Monitor clock off hides reference A presence
package pgd_regs_pkg;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_STATUS  = 12'h01F;
	localparam logic [11:0] IDX_DRV0    = 12'h0F0;
	localparam logic [11:0] IDX_DRV1    = 12'h0F1;
	localparam logic [11:0] IDX_DRV2    = 12'h0F2;
	localparam logic [11:0] IDX_DRV3    = 12'h0F3;
	localparam logic [11:0] IDX_MONCTL  = 12'h020;

	// Field positions in the status byte
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_REF_INPUT_A_BIT = 1;
	localparam int STAT_REF_INPUT_B_BIT = 2;
	localparam int STAT_FB_BIT   = 3;
	localparam int STAT_SEL_BIT  = 4;

	// Field positions in a driver byte
	localparam int DRV_PD_BIT    = 0;
	localparam int DRV_SWING_LO  = 1;
	localparam int DRV_PAIR_BIT  = 4;

	// Swing codes: 400, 600, 780, 960 mV
	localparam logic [1:0] SWING_400 = 2'h0;
	localparam logic [1:0] SWING_600 = 2'h1;
	localparam logic [1:0] SWING_780 = 2'h2;
	localparam logic [1:0] SWING_960 = 2'h3;

	// Reset values
	localparam logic        MON_OFF_RST = 1'b0;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

	// One output driver's control
	typedef struct packed {
		logic       pairPd;
		logic [1:0] swing;
		logic       drvPd;
	} pgd_drv_t;

	// Live PLL status inputs
	typedef struct packed {
		logic refSelB;
		logic fbPresent;
		logic refBPresent;
		logic refAPresent;
		logic lockFlag;
	} pgd_stat_t;

	localparam pgd_drv_t DRV_RST = '{pairPd: 1'b0, swing: SWING_780, drvPd: 1'b0};

	// Byte address of a register index
	function automatic logic [11:0] addrOf(input logic [11:0] idx);
		addrOf = {idx[9:0], 2'b00};
	endfunction

endpackage

// ### verilog/pgd_regs.sv
// APB register bank: live PLL status readback and four output driver controls
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module pgd_regs
	import pgd_regs_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            reset_n,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	input  wire logic [3:0]      pstrb,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire pgd_stat_t       pllStatus,
	output pgd_drv_t  [3:0]      drvCfg,
	output logic                 refAMonClkOff,
	output logic                 autoSwitchEn
);

	pgd_stat_t       statMeta_q;    // First sync stage, read by second only
	pgd_stat_t       stat_q;        // Synchronised status
	logic            pready_q;      // Access phase answer
	logic [31:0]     prdata_q;      // Captured read data
	logic            pslverr_q;     // Unmapped address answer
	pgd_drv_t [3:0]  drv_q;         // Driver controls
	logic            monOff_q;      // Reference A monitor clock off
	logic            autoSw_q;      // Automatic switchover allowed
	logic            access;        // Access phase, not yet answered
	logic            wrDone;        // Write commits this edge
	logic [7:0]      statByte;      // Live status byte
	logic            refAShown;     // Reference A presence as reported
	logic [2:0]      drvHit;        // Raw driver decode, 4 for none
	logic            statHit;       // Address names the status byte
	logic            monHit;        // Address names the monitor control
	logic            drvAny;        // Address names one of the drivers
	logic [1:0]      drvSel;        // Which driver, valid with drvAny
	logic            strobeLo;      // Low byte lane enabled
	logic            drvWr;         // Driver write commits this edge
	logic            monWr;         // Monitor control write commits this edge
	logic [31:0]     rdNext;        // Read data for the current address
	logic            errNext;       // Error answer for the current address

	// Answer takes one wait cycle so every bus output comes from a flop
	assign access = psel && penable && !pready_q;
	assign wrDone = psel && penable && pready_q && pwrite;

	// Address match helper
	function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
		hit = (a == addrOf(idx));
	endfunction

	// Index of a driver register, or 4 for none
	function automatic logic [2:0] drvIdx(input logic [11:0] a);
		if (hit(a, IDX_DRV0)) begin
			drvIdx = 3'h0;
		end else if (hit(a, IDX_DRV1)) begin
			drvIdx = 3'h1;
		end else if (hit(a, IDX_DRV2)) begin
			drvIdx = 3'h2;
		end else if (hit(a, IDX_DRV3)) begin
			drvIdx = 3'h3;
		end else begin
			drvIdx = 3'h4;
		end
	endfunction

	// Raw driver decode; 4 means none of the four drivers
	assign drvHit = drvIdx(paddr);

	// Address decode, done once so the read mux and the write paths agree.
	// The driver select is two bits; drvAny guards every use of it, so an
	// unmapped address never indexes past the last driver.
	always_comb begin
		statHit = 1'b0;
		monHit  = 1'b0;
		drvAny  = 1'b0;
		drvSel  = 2'h0;
		if (hit(paddr, IDX_STATUS)) begin
			// Read-only status byte
			statHit = 1'b1;
		end else if (hit(paddr, IDX_MONCTL)) begin
			// Reference A monitor clock gate
			monHit = 1'b1;
		end else if (drvHit != 3'h4) begin
			// One of the four output drivers
			drvAny = 1'b1;
			drvSel = drvHit[1:0];
		end
	end

	// Only the low lane carries a register byte
	assign strobeLo = pstrb[0];
	// Writes land at the edge where the answer is sampled
	assign drvWr    = wrDone && strobeLo && drvAny;
	assign monWr    = wrDone && strobeLo && monHit;

	// Status pins come from the PLL domain, so two flops first.
	// Each bit is a slow level, so a bit that lands one cycle apart from
	// its neighbours only skews one read, never corrupts a stored value.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			statMeta_q <= '0;
			stat_q     <= '0;
		end else begin
			statMeta_q <= pllStatus;
			stat_q     <= statMeta_q;
		end
	end

	// No monitor clock means no valid presence for reference A
	assign refAShown = stat_q.refAPresent && !monOff_q;

	// Live status byte; upper bits carry nothing
	always_comb begin
		statByte               = 8'h00;
		statByte[STAT_SEL_BIT] = stat_q.refSelB;
		statByte[STAT_FB_BIT]  = stat_q.fbPresent;
		statByte[STAT_REF_INPUT_B_BIT] = stat_q.refBPresent;
		statByte[STAT_REF_INPUT_A_BIT] = refAShown;
		statByte[STAT_LOCK_BIT] = stat_q.lockFlag;
	end

	// Read data for whatever the address names. Bits outside the byte, and
	// the ignored driver bits 7:5 and 3, always read zero so software may
	// compare whole words. Odd drivers read bit 4 as zero, it is never
	// stored there.
	always_comb begin
		rdNext  = RDATA_RST;
		errNext = 1'b0;
		if (statHit) begin
			// Live byte, sampled at the decode edge, never a stale copy
			rdNext[7:0] = statByte;
		end else if (monHit) begin
			// Monitor clock gate readback
			rdNext[0] = monOff_q;
		end else if (drvAny) begin
			// Driver fields at their byte positions
			rdNext[DRV_PAIR_BIT]      = drv_q[drvSel].pairPd;
			rdNext[DRV_SWING_LO +: 2] = drv_q[drvSel].swing;
			rdNext[DRV_PD_BIT]        = drv_q[drvSel].drvPd;
		end else begin
			// Unmapped: error answer, data zero
			errNext = 1'b1;
		end
	end

	// Bus answer: one wait cycle, then pready, prdata and pslverr stand
	// for one cycle. Costs a cycle per transfer but keeps every bus output
	// on a flop, which the pads and timing want.
	// Bus answer and read data capture
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= RDATA_RST;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= access;
			pslverr_q <= 1'b0;
			prdata_q  <= RDATA_RST;
			if (access) begin
				// Capture at the first access cycle, shown in the next
				prdata_q  <= rdNext;
				pslverr_q <= errNext;
			end
		end
	end

	// Driver control writes; only the low byte lane matters
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			drv_q <= {4{DRV_RST}};
		end else if (drvWr) begin
			drv_q[drvSel].swing <= pwdata[DRV_SWING_LO +: 2];
			drv_q[drvSel].drvPd <= pwdata[DRV_PD_BIT];
			// Pair control lives only in even drivers; odd bit 4 is reserved
			if (drvSel == 2'h0) begin
				drv_q[0].pairPd <= pwdata[DRV_PAIR_BIT];
			end else if (drvSel == 2'h2) begin
				drv_q[2].pairPd <= pwdata[DRV_PAIR_BIT];
			end
		end
	end

	// Monitor clock control; a status write lands nowhere
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			monOff_q <= MON_OFF_RST;
			autoSw_q <= !MON_OFF_RST;
		end else begin
			// Gate bit stored only from a strobed write to its own index
			if (monWr) begin
				monOff_q <= pwdata[0];
			end
			// Switchover needs the monitor, so it follows the clock gate
			autoSw_q <= !monOff_q;
		end
	end

	// Every output is a flop; no logic sits between register and pin,
	// so downstream timing sees a clean clock-to-out.
	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign drvCfg        = drv_q;
	assign refAMonClkOff = monOff_q;
	assign autoSwitchEn  = autoSw_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Status read answer checks; the answer cycle shows what the flops
	// held at the capture edge one cycle earlier
	sel_ref_a: assert property (
		pready_q && !pwrite && statHit
		|-> prdata_q[STAT_SEL_BIT] == $past(stat_q.refSelB))
		else $error("Selected reference bit wrong");
	fb_present_a: assert property (
		pready_q && !pwrite && statHit
		|-> prdata_q[STAT_FB_BIT] == $past(stat_q.fbPresent))
		else $error("Feedback presence bit wrong");
	ref_input_b_present_a: assert property (
		pready_q && !pwrite && statHit
		|-> prdata_q[STAT_REF_INPUT_B_BIT] == $past(stat_q.refBPresent))
		else $error("Reference B presence bit wrong");
	ref_input_a_present_a: assert property (
		pready_q && !pwrite && statHit
		|-> prdata_q[STAT_REF_INPUT_A_BIT] == $past(refAShown))
		else $error("Reference A presence bit wrong");
	lock_flag_a: assert property (
		pready_q && !pwrite && statHit
		|-> prdata_q[STAT_LOCK_BIT] == $past(stat_q.lockFlag))
		else $error("Lock flag bit wrong");
	status_upper_a: assert property (
		pready_q && statHit
		|-> prdata_q[31:5] == 27'h000_0000)
		else $error("Status upper bits not zero");
	status_wr_a: assert property (
		pready_q && pwrite && statHit
		|-> !pslverr_q)
		else $error("Status write answered with error");

	// Driver write checks; a strobed write lands at the answer edge and
	// shows on the port one cycle later
	pair_zero_a: assert property (
		drvWr && drvSel == 2'h0
		|=> drvCfg[0].pairPd == $past(pwdata[DRV_PAIR_BIT]))
		else $error("Pair 0/1 power-down not stored");
	pair_keep_a: assert property (
		drvWr && drvSel != 2'h0
		|=> $stable(drvCfg[0].pairPd))
		else $error("Pair 0/1 power-down changed by other write");
	pair_two_a: assert property (
		drvWr && drvSel == 2'h2
		|=> drvCfg[2].pairPd == $past(pwdata[DRV_PAIR_BIT]))
		else $error("Pair 2/3 power-down not stored");
	pair_keep_two_a: assert property (
		drvWr && drvSel != 2'h2
		|=> $stable(drvCfg[2].pairPd))
		else $error("Pair 2/3 power-down changed by other write");
	swing_zero_a: assert property (
		drvWr && drvSel == 2'h0
		|=> drvCfg[0].swing == $past(pwdata[2:1]))
		else $error("Driver 0 swing select not stored");
	swing_one_a: assert property (
		drvWr && drvSel == 2'h1
		|=> drvCfg[1].swing == $past(pwdata[2:1]))
		else $error("Driver 1 swing select not stored");
	swing_two_a: assert property (
		drvWr && drvSel == 2'h2
		|=> drvCfg[2].swing == $past(pwdata[2:1]))
		else $error("Driver 2 swing select not stored");
	swing_sel_a: assert property (
		drvWr && drvSel == 2'h3
		|=> drvCfg[3].swing == $past(pwdata[2:1]))
		else $error("Swing select not stored");
	pd_zero_a: assert property (
		drvWr && drvSel == 2'h0
		|=> drvCfg[0].drvPd == $past(pwdata[0]))
		else $error("Driver 0 power-down not stored");
	drv_pd_a: assert property (
		drvWr && drvSel == 2'h1
		|=> drvCfg[1].drvPd == $past(pwdata[0]) && drvCfg[1].pairPd == 1'b0)
		else $error("Driver power-down wrong");
	pd_two_a: assert property (
		drvWr && drvSel == 2'h2
		|=> drvCfg[2].drvPd == $past(pwdata[0]))
		else $error("Driver 2 power-down not stored");
	pd_three_a: assert property (
		drvWr && drvSel == 2'h3
		|=> drvCfg[3].drvPd == $past(pwdata[0]))
		else $error("Driver 3 power-down not stored");
	strobe_gate_a: assert property (
		psel && penable && pready_q && pwrite && !strobeLo
		|=> $stable(drvCfg) && $stable(refAMonClkOff))
		else $error("Write without low strobe changed state");

	// Ignored and reserved driver bits never show up
	drv_ignored_a: assert property (
		pready_q && !pwrite && drvAny
		|-> prdata_q[31:5] == 27'h000_0000 && !prdata_q[3])
		else $error("Ignored driver bits read nonzero");
	odd_pair_a: assert property (
		!drvCfg[1].pairPd && !drvCfg[3].pairPd)
		else $error("Odd driver reserved bit stored");

	// Monitor clock gate: presence hidden at once, switchover a cycle later
	mon_gate_a: assert property (
		monOff_q
		|-> !refAShown ##1 !autoSwitchEn)
		else $error("Monitor gating not applied");
	mon_store_a: assert property (
		monWr
		|=> refAMonClkOff == $past(pwdata[0]))
		else $error("Monitor clock gate not stored");
	auto_follow_a: assert property (
		1'b1
		|=> autoSwitchEn == !$past(refAMonClkOff))
		else $error("Switchover enable does not follow gate");
	ref_input_a_hidden_a: assert property (
		pready_q && !pwrite && statHit && $past(monOff_q)
		|-> !prdata_q[STAT_REF_INPUT_A_BIT])
		else $error("Reference A presence shown while unmonitored");

	// A write aimed at the status byte lands nowhere
	status_ro_a: assert property (
		wrDone && statHit
		|=> $stable(drvCfg) && $stable(refAMonClkOff))
		else $error("Status write changed state");

	// Main scenarios
	cov_status_rd: cover property (pready_q && !pwrite && hit(paddr, IDX_STATUS));
	cov_drv_wr: cover property (wrDone && hit(paddr, IDX_DRV2));
	cov_unmapped: cover property (pslverr_q);
	cov_mon_off: cover property (monOff_q && stat_q.refAPresent);
	cov_no_strobe: cover property (psel && penable && pready_q && pwrite && !strobeLo);

endmodule

// ### verification/pll_status_and_output_driver_regs_tb.sv
// Testbench for the PLL status and output driver register bank
`timescale 1ns/100ps
module pll_status_and_output_driver_regs_tb
	import pgd_regs_pkg::*;
;
	logic            core_clk;      // Bus clock, 25 MHz
	logic            reset_n;       // Sync reset, active low
	logic            psel;          // Bus select
	logic            penable;       // Access phase
	logic            pwrite;        // Direction
	logic [11:0]     paddr;         // Byte address
	logic [31:0]     pwdata;        // Write data
	logic [3:0]      pstrb;         // Byte strobes
	logic [31:0]     prdata;        // Read data
	logic            pready;        // Answer
	logic            pslverr;       // Error answer
	pgd_stat_t       pllStatus;     // Live status pins
	pgd_drv_t  [3:0] drvCfg;        // Driver controls
	logic            refAMonClkOff; // Monitor clock off
	logic            autoSwitchEn;  // Switchover enable
	int              nFail;         // Mismatch count
	int              checks;        // Comparison count
	int              cycles;        // Timeout counter
	logic [31:0]     rd;            // Last read data
	logic            err;           // Last error flag

	pgd_regs pgd_regs_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pllStatus(pllStatus),
		.drvCfg(drvCfg), .refAMonClkOff(refAMonClkOff), .autoSwitchEn(autoSwitchEn));

	// Clock, 40 ns period
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			nFail++;
		end
	endtask

	// One bus transfer; waits for pready, bounded so a hang is caught
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {idx[9:0], 2'b00};
		pwdata  <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) nFail++;
	endtask

	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Hang guard; the whole run needs well under this
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nFail++;
			test_done();
		end
	end

	// Reset defaults: swing 780 mV, everything enabled
	task automatic t_reset;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, IDX_DRV0 + 12'(k), 32'h0000_0000);
			chk("drv reset read", rd, 32'h0000_0004);
			chk("drv reset port", 32'(drvCfg[k]), 32'h0000_0004);
		end
	endtask

	// Each live status bit alone, then a write that must not stick
	task automatic t_status;
		for (int i = 0; i < 5; i++) begin
			pllStatus <= pgd_stat_t'(5'h01 << i);
			repeat (4) @(posedge core_clk);
			apb(1'b0, IDX_STATUS, 32'h0000_0000);
			chk("status bit", rd, 32'h0000_0001 << i);
		end
		apb(1'b1, IDX_STATUS, 32'h0000_00FF);
		apb(1'b0, IDX_STATUS, 32'h0000_0000);
		chk("status ro", rd, 32'h0000_0010);
	endtask

	// All ones on even drivers and EF on odd drivers, then every swing code, on each driver
	task automatic t_driver;
		logic [31:0] wd;
		for (int k = 0; k < 4; k++) begin
			// Odd drivers: reserved bit 4 kept zero, ignored bits set
			wd = (k % 2 == 0) ? 32'h0000_00FF : 32'h0000_00EF;
			apb(1'b1, IDX_DRV0 + 12'(k), wd);
			apb(1'b0, IDX_DRV0 + 12'(k), 32'h0000_0000);
			chk("drv ones", rd, (k % 2 == 0) ? 32'h0000_0017 : 32'h0000_0007);
			for (int s = 0; s < 4; s++) begin
				apb(1'b1, IDX_DRV0 + 12'(k), 32'(s) << 1);
				// Port updates at the committing edge; look one edge later
				@(posedge core_clk);
				chk("swing", 32'(drvCfg[k].swing), 32'(s));
				chk("drv pd", 32'(drvCfg[k].drvPd), 32'h0000_0000);
			end
		end
		// Write without the low lane strobe must leave driver 0 alone
		pstrb <= 4'h0;
		apb(1'b1, IDX_DRV0, 32'h0000_0011);
		pstrb <= 4'h1;
		apb(1'b0, IDX_DRV0, 32'h0000_0000);
		chk("no strobe", rd, 32'h0000_0006);
	endtask

	// Monitor clock off hides ref A presence; unmapped place errors
	task automatic t_monitor;
		pllStatus <= pgd_stat_t'(5'h02);
		apb(1'b1, IDX_MONCTL, 32'h0000_0001);
		repeat (4) @(posedge core_clk);
		apb(1'b0, IDX_STATUS, 32'h0000_0000);
		chk("ref_input_a hidden", rd, 32'h0000_0000);
		chk("status err", 32'(err), 32'h0000_0000);
		chk("auto switch", 32'(autoSwitchEn), 32'h0000_0000);
		chk("mon clk off", 32'(refAMonClkOff), 32'h0000_0001);
		apb(1'b0, IDX_MONCTL, 32'h0000_0000);
		chk("mon readback", rd, 32'h0000_0001);
		apb(1'b1, IDX_MONCTL, 32'h0000_0000);
		apb(1'b0, IDX_STATUS, 32'h0000_0000);
		chk("ref_input_a shown", rd, 32'h0000_0002);
		chk("auto switch on", 32'(autoSwitchEn), 32'h0000_0001);
		chk("mon clk on", 32'(refAMonClkOff), 32'h0000_0000);
		apb(1'b0, 12'h0010, 32'h0000_0000);
		chk("unmapped err", 32'(err), 32'h0000_0001);
	endtask

	// Main sequence
	initial begin
		nFail = 0;
		checks = 0;
		cycles = 0;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h1;
		pllStatus = '0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_status();
		t_driver();
		t_monitor();
		test_done();
	end
endmodule
